// ### rtl/cdsc_top.sv
// top: charger detection sequencer, pin outputs and axi4-lite registers
module cdsc_top
   import cdsc_pkg::*;
#(
   parameter longint unsigned DEBOUNCE_CYCLES = cdsc_pkg::DEBOUNCE_CYC,
   parameter longint unsigned TIMEOUT_CYCLES = cdsc_pkg::DETECT_TIMEOUT_CYC,
   parameter longint unsigned DBT_CYCLES = cdsc_pkg::DBT_CYC
) (
   input wire logic ref_clk, // 125 mhz clock
   input wire logic rst, // sync reset, active high
   input wire logic bus_valid_in, // supply valid pin
   input wire logic battery_ok_in, // battery good from host
   input wire logic detect_done_in, // front end finished
   input wire logic [2:0] detect_class_in, // front end class
   output logic switch_state_out, // open-drain level, always 0
   output logic switch_state_oe, // low drive, switches closed
   output logic charge_allowed_n, // open-drain level, always 0
   output logic charge_allowed_oe, // low drive, charging allowed
   output logic charger_found_out, // push-pull, high current
   output logic detect_run_out, // front end enable
   output logic irq, // level interrupt
   input wire logic [3:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // aw valid
   output logic s_axi_awready, // aw ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // w valid
   output logic s_axi_wready, // w ready
   output logic [1:0] s_axi_bresp, // write resp
   output logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [3:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // ar valid
   output logic s_axi_arready, // ar ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read resp
   output logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   import cdsc_pkg::*;

   // counts of zero, or a dbt count wider than the counter, cannot be served
   if (DEBOUNCE_CYCLES < 1 || TIMEOUT_CYCLES < 1 || DBT_CYCLES < 1 || DBT_CYCLES >= (64'h1 << CNT_W)) begin : g_bad_counts
      $error("cdsc_top: bad cycle counts");
   end

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [5:0] pins_s;
   cdsc_sync #(.W(6)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({detect_class_in, detect_done_in, battery_ok_in, bus_valid_in}),
      .q(pins_s)
   );
   logic vbus, bat_ok, fe_done;
   cdsc_class_t fe_class;
   assign vbus = pins_s[0];
   assign bat_ok = pins_s[1];
   assign fe_done = pins_s[2];
   assign fe_class = cdsc_class_t'(pins_s[5:3]);

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   typedef enum logic [2:0] {CDSC_IDLE, CDSC_DEBOUNCE, CDSC_DETECT, CDSC_DONE, CDSC_EXPIRED} cdsc_state_t;
   cdsc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   cdsc_class_t class_reg, class_next;
   logic bat_prev_reg, bat_prev_next;
   logic sw_oe_reg, sw_oe_next, chg_oe_reg, chg_oe_next, found_reg, found_next, run_reg, run_next;
   logic ev_done, ev_dbt, ev_lost;
   logic std_port;
   assign std_port = (class_reg == CDSC_CLS_SDP) || (class_reg == CDSC_CLS_CDP);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      class_next = class_reg;
      bat_prev_next = bat_ok;
      sw_oe_next = sw_oe_reg;
      chg_oe_next = chg_oe_reg;
      found_next = found_reg;
      run_next = 1'b0;
      ev_done = 1'b0;
      ev_dbt = 1'b0;
      ev_lost = 1'b0;
      if (!vbus) begin
         // supply gone: back to no-device outputs
         if (state_reg != CDSC_IDLE) begin
            ev_lost = 1'b1;
         end
         state_next = CDSC_IDLE;
         cnt_next = '0;
         sw_oe_next = 1'b0;
         chg_oe_next = 1'b0;
         found_next = 1'b0;
      end else begin
         unique case (state_reg)
            CDSC_IDLE: begin
               state_next = CDSC_DEBOUNCE;
               cnt_next = '0;
            end
            CDSC_DEBOUNCE: begin
               cnt_next = cnt_reg + 1'b1;
               if (cnt_reg + 1'b1 >= CNT_W'(DEBOUNCE_CYCLES)) begin
                  state_next = CDSC_DETECT;
                  cnt_next = '0;
               end
            end
            CDSC_DETECT: begin
               run_next = 1'b1;
               cnt_next = cnt_reg + 1'b1;
               if (fe_done || cnt_reg + 1'b1 >= CNT_W'(TIMEOUT_CYCLES)) begin
                  // outputs are set here at the end of detection; the switch can still close later in done
                  class_next = fe_done ? fe_class : CDSC_CLS_NONSTD;
                  run_next = 1'b0;
                  state_next = CDSC_DONE;
                  cnt_next = '0;
                  ev_done = 1'b1;
                  chg_oe_next = 1'b1;
                  found_next = fe_done && (fe_class == CDSC_CLS_CDP || fe_class == CDSC_CLS_DCP
                     || fe_class == CDSC_CLS_PROP);
                  sw_oe_next = fe_done && bat_ok
                     && (fe_class == CDSC_CLS_SDP || fe_class == CDSC_CLS_CDP);
               end
            end
            CDSC_DONE: begin
               // timer runs only while battery ok is low
               if (bat_ok) begin
                  cnt_next = '0;
                  if (std_port) begin
                     sw_oe_next = 1'b1;
                  end
               end else begin
                  cnt_next = cnt_reg + 1'b1;
                  if (cnt_reg + 1'b1 >= CNT_W'(DBT_CYCLES)) begin
                     state_next = CDSC_EXPIRED;
                     chg_oe_next = 1'b0;
                     found_next = 1'b0;
                     sw_oe_next = 1'b0;
                     ev_dbt = 1'b1;
                  end
               end
            end
            CDSC_EXPIRED: begin
               if (bat_ok && !bat_prev_reg) begin
                  state_next = CDSC_DEBOUNCE;
                  cnt_next = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= CDSC_IDLE;
         cnt_reg <= '0;
         class_reg <= CDSC_CLS_NONE;
         bat_prev_reg <= 1'b0;
         sw_oe_reg <= 1'b0;
         chg_oe_reg <= 1'b0;
         found_reg <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         class_reg <= class_next;
         bat_prev_reg <= bat_prev_next;
         sw_oe_reg <= sw_oe_next;
         chg_oe_reg <= chg_oe_next;
         found_reg <= found_next;
         run_reg <= run_next;
      end
   end

   assign switch_state_out = 1'b0;
   assign switch_state_oe = sw_oe_reg;
   assign charge_allowed_n = 1'b0;
   assign charge_allowed_oe = chg_oe_reg;
   assign charger_found_out = found_reg;
   assign detect_run_out = run_reg;

   // ------------------------------------------------------------
   // axi4-lite slave and interrupt
   // ------------------------------------------------------------
   logic [IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
   logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next, irq_reg, irq_next;
   logic [3:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
   logic [1:0] br_reg, br_next, rr_reg, rr_next;
   logic [IRQ_W-1:0] ev;
   assign ev = {ev_lost, ev_dbt, ev_done};

   always_comb begin
      aw_next = aw_reg;
      w_next = w_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      bv_next = bv_reg;
      br_next = br_reg;
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      imask_next = imask_reg;
      ist_next = ist_reg;
      if (s_axi_awvalid && !aw_reg && !bv_reg) begin
         aw_next = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_reg && !bv_reg) begin
         w_next = 1'b1;
         wd_next = s_axi_wdata;
      end
      if (aw_reg && w_reg) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         br_next = RESP_OKAY;
         if (awa_reg == ADDR_IRQ_MASK) begin
            imask_next = wd_reg[IRQ_W-1:0];
         end else if (awa_reg != ADDR_CTRL && awa_reg != ADDR_STATUS && awa_reg != ADDR_IRQ_STAT) begin
            br_next = RESP_SLVERR;
         end
      end
      if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (s_axi_arvalid && !rv_reg) begin
         rv_next = 1'b1;
         rr_next = RESP_OKAY;
         rd_next = '0;
         unique case (s_axi_araddr)
            ADDR_CTRL: begin
               rd_next[CTRL_BUS_VALID] = vbus;
               rd_next[CTRL_DONE] = (state_reg == CDSC_DONE);
               rd_next[CTRL_CLASS_LSB +: 3] = class_reg;
            end
            ADDR_STATUS: rd_next[3:0] = {bat_ok, found_reg, chg_oe_reg, sw_oe_reg};
            ADDR_IRQ_STAT: begin
               rd_next[IRQ_W-1:0] = ist_reg;
               ist_next = '0; // read clears
            end
            ADDR_IRQ_MASK: rd_next[IRQ_W-1:0] = imask_reg;
            default: rr_next = RESP_SLVERR;
         endcase
      end
      if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
      ist_next = ist_next | ev; // set wins over read clear
      irq_next = |(ist_next & imask_next);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awa_reg <= '0;
         wd_reg <= '0;
         bv_reg <= 1'b0;
         br_reg <= RESP_OKAY;
         rv_reg <= 1'b0;
         rd_reg <= '0;
         rr_reg <= RESP_OKAY;
         imask_reg <= '0;
         ist_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         aw_reg <= aw_next;
         w_reg <= w_next;
         awa_reg <= awa_next;
         wd_reg <= wd_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
         imask_reg <= imask_next;
         ist_reg <= ist_next;
         irq_reg <= irq_next;
      end
   end

   assign s_axi_awready = !aw_reg && !bv_reg;
   assign s_axi_wready = !w_reg && !bv_reg;
   assign s_axi_bvalid = bv_reg;
   assign s_axi_bresp = br_reg;
   assign s_axi_arready = !rv_reg;
   assign s_axi_rvalid = rv_reg;
   assign s_axi_rdata = rd_reg;
   assign s_axi_rresp = rr_reg;
   assign irq = irq_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_switch_open_idle: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CDSC_IDLE) |-> !switch_state_oe) else $error("switch closed while idle");
   a_found_push_pull: assert property (@(posedge ref_clk) disable iff (rst)
      charger_found_out |-> charge_allowed_oe) else $error("found without charge allowed");
   a_close_needs_bat: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(switch_state_oe) |-> $past(bat_ok) && $past(vbus)) else $error("closed without battery ok");
   a_debounce_len: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(detect_run_out) |-> $past(state_reg, 2) == CDSC_DEBOUNCE && $past(cnt_reg, 2) + 1 >= DEBOUNCE_CYCLES)
      else $error("detection began early");
   a_timeout_class: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CDSC_DETECT && !fe_done && vbus && cnt_reg + 1 >= TIMEOUT_CYCLES)
      |=> class_reg == CDSC_CLS_NONSTD) else $error("timeout not nonstandard");
   a_outputs_at_end: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(charge_allowed_oe) |-> $past(state_reg) == CDSC_DETECT) else $error("output changed mid-sequence");
   a_dbt_expiry: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CDSC_EXPIRED) |-> !charge_allowed_oe) else $error("charging after timer expiry");
   a_dbt_hold_bat: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CDSC_DONE && bat_ok && vbus) |=> cnt_reg == 0) else $error("timer ran with battery ok");
   a_bus_loss_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !vbus |=> !switch_state_oe && !charge_allowed_oe && !charger_found_out) else $error("outputs kept after loss");
   a_sdp_close: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == CDSC_DONE && vbus && bat_ok && std_port) |=> switch_state_oe) else $error("sdp not closed");
endmodule : cdsc_top

// ### rtl/cdsc_pkg.sv
// package: constants and types for the charger detection status control block
package cdsc_pkg;
   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned DEBOUNCE_MS = 130;
   localparam int unsigned DETECT_TIMEOUT_MS = 600;
   localparam int unsigned DBT_MINUTES = 30;
   localparam int unsigned DBT_MAX_MINUTES = 45;
   localparam longint unsigned DEBOUNCE_CYC = longint'(CLK_HZ) / 1000 * DEBOUNCE_MS;
   localparam longint unsigned DETECT_TIMEOUT_CYC = longint'(CLK_HZ) / 1000 * DETECT_TIMEOUT_MS;
   localparam longint unsigned DBT_CYC = longint'(CLK_HZ) * 60 * DBT_MINUTES;
   localparam int CNT_W = 38;

   // ------------------------------------------------------------
   // axi4-lite register map
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ctrl fields
   localparam int CTRL_BUS_VALID = 0;
   localparam int CTRL_DONE = 1;
   localparam int CTRL_CLASS_LSB = 4;
   // irq bits: detection done, timer expired, bus lost
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_DBT = 1;
   localparam int IRQ_LOST = 2;

   // attached source classes reported by the analog front end
   typedef enum logic [2:0] {
      CDSC_CLS_NONE = 3'h0,
      CDSC_CLS_SDP = 3'h1,
      CDSC_CLS_CDP = 3'h2,
      CDSC_CLS_DCP = 3'h3,
      CDSC_CLS_PROP = 3'h4,
      CDSC_CLS_NONSTD = 3'h5
   } cdsc_class_t;
endpackage : cdsc_pkg

// ### rtl/cdsc_sync.sv
// two flip-flop synchroniser for pin inputs
module cdsc_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk, // clock
   input wire logic rst, // sync reset
   input wire logic [W-1:0] d, // async input
   output logic [W-1:0] q // synchronised
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end
   assign q = s2_reg;
endmodule : cdsc_sync

// ### verification/cdsc_host_model.sv
// host controller model: reports battery state and watches the open-drain status pins
module cdsc_host_model (
   input wire logic ref_clk, // clock
   input wire logic bat_cmd, // battery state the bench wants reported
   input wire logic switch_state_out, // open-drain level
   input wire logic switch_state_oe, // open-drain enable
   input wire logic charge_allowed_n, // open-drain level
   input wire logic charge_allowed_oe, // open-drain enable
   output logic battery_ok_in, // battery good to the device
   output logic sw_pin, // switch pin after pull-up
   output logic chg_pin, // charge pin after pull-up
   output int sw_changes // open/close events seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sw_last = 1'b1;
   int sw_seen = 0;
   assign sw_changes = sw_seen;
   always @(posedge ref_clk) battery_ok_in <= bat_cmd;
   // pull-ups take the pins high whenever the device lets go
   assign sw_pin = switch_state_oe ? switch_state_out : 1'b1;
   assign chg_pin = charge_allowed_oe ? charge_allowed_n : 1'b1;
   always @(posedge ref_clk) begin
      sw_last <= sw_pin;
      if (sw_last !== sw_pin) sw_seen <= sw_seen + 1;
   end
endmodule : cdsc_host_model

// ### verification/cdsc_top_tb.sv
// testbench for the charger detection status control block
module cdsc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cdsc_pkg::*;
   // short counts keep the run small
   localparam longint unsigned DEB = 20;
   localparam longint unsigned TMO = 50;
   localparam longint unsigned DBT = 100;
   logic ref_clk = 0, rst = 1, bus_v = 0, bat_cmd = 0, done = 0;
   logic [2:0] cls = 0;
   logic [3:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic bat, sw_oe, sw_o, ca_oe, ca_n, found, run, irq, awready, wready, bvalid, arready, rvalid, sw_pin, chg_pin;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_count = 0, compares = 0, sw_changes, n0, i;
   always #4 ref_clk = ~ref_clk;
   cdsc_top #(.DEBOUNCE_CYCLES(DEB), .TIMEOUT_CYCLES(TMO), .DBT_CYCLES(DBT)) dut (.ref_clk(ref_clk), .rst(rst),
      .bus_valid_in(bus_v), .battery_ok_in(bat), .detect_done_in(done), .detect_class_in(cls),
      .switch_state_out(sw_o), .switch_state_oe(sw_oe), .charge_allowed_n(ca_n), .charge_allowed_oe(ca_oe),
      .charger_found_out(found), .detect_run_out(run), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cdsc_host_model host (.ref_clk(ref_clk), .bat_cmd(bat_cmd), .switch_state_out(sw_o), .switch_state_oe(sw_oe),
      .charge_allowed_n(ca_n), .charge_allowed_oe(ca_oe), .battery_ok_in(bat), .sw_pin(sw_pin), .chg_pin(chg_pin),
      .sw_changes(sw_changes));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task summarize;
      $display("mismatches %0d, comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task bound(input int k, input int lim);
      if (k >= lim) begin
         check(k, 0);
         summarize;
      end
   endtask : bound
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      // one edge apart, so bready is never set twice in one step
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bound(i, 50);
      bready <= 1'b0;
      check(bresp, er);
   endtask : axi_wr
   task axi_rd(input logic [3:0] a, input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      bound(i, 50);
      rready <= 1'b0;
      d = rdata;
      check(rresp, er);
   endtask : axi_rd
   task rd_chk(input logic [3:0] a, input logic [31:0] exp);
      axi_rd(a, RESP_OKAY);
      check(d, exp);
   endtask : rd_chk
   // without done the window must run out on its own
   task detect(input logic [2:0] c, input logic b, input bit use_done);
      bat_cmd <= b;
      bus_v <= 1'b1;
      for (i = 0; i < DEB + 20; i++) begin
         @(posedge ref_clk);
         if (run === 1'b1) break;
      end
      bound(i, DEB + 20);
      check(i >= DEB && i <= DEB + 8, 1);
      check({sw_oe, ca_oe, found}, 0);
      if (use_done) begin
         cls <= c;
         done <= 1'b1;
      end
      for (i = 0; i < TMO + 20; i++) begin
         @(posedge ref_clk);
         if (run === 1'b0) break;
      end
      bound(i, TMO + 20);
      if (!use_done) check(i >= TMO - 3 && i <= TMO + 4, 1);
      tick(2);
      done <= 1'b0;
   endtask : detect
   task expect_out(input logic [2:0] c, input logic b);
      logic cl;
      logic hi;
      cl = b && (c == CDSC_CLS_SDP || c == CDSC_CLS_CDP);
      hi = c == CDSC_CLS_CDP || c == CDSC_CLS_DCP || c == CDSC_CLS_PROP;
      check(sw_oe, cl);
      check(sw_pin, !cl);
      check({ca_oe, chg_pin}, 2'h2);
      check(found, hi);
      check({sw_o, ca_n}, 0);
   endtask : expect_out
   task drop;
      bus_v <= 1'b0;
      tick(5);
      check({sw_oe, ca_oe, found, run}, 0);
      tick(3);
   endtask : drop
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      tick(4);
      rst <= 1'b0;
      tick(1);
      check({sw_oe, ca_oe, found, irq, run}, 0);
      rd_chk(ADDR_CTRL, 32'h0);
      rd_chk(ADDR_STATUS, 32'h0);
      axi_rd(4'h2, RESP_SLVERR);
      check(d, 32'h0);
      axi_wr(4'h6, 32'h0, RESP_SLVERR);
      axi_wr(ADDR_CTRL, 32'hffffffff, RESP_OKAY);
      rd_chk(ADDR_CTRL, 32'h0);
      axi_wr(ADDR_IRQ_MASK, 32'hffffffff, RESP_OKAY);
      rd_chk(ADDR_IRQ_MASK, 32'h7);
      rd_chk(ADDR_IRQ_STAT, 32'h0);
      n0 = sw_changes;
      detect(CDSC_CLS_SDP, 1'b1, 1'b1);
      expect_out(CDSC_CLS_SDP, 1'b1);
      check(sw_changes - n0, 1);
      check(irq, 1);
      rd_chk(ADDR_IRQ_STAT, 32'h1);
      tick(2);
      check(irq, 0);
      rd_chk(ADDR_IRQ_STAT, 32'h0);
      rd_chk(ADDR_STATUS, 32'hb);
      rd_chk(ADDR_CTRL, 32'h13);
      axi_wr(ADDR_IRQ_MASK, 32'h4, RESP_OKAY);
      drop;
      check(irq, 1);
      rd_chk(ADDR_IRQ_STAT, 32'h4);
      axi_wr(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
      for (int c = 1; c <= 5; c++) begin
         for (int b = 0; b <= 1; b++) begin
            detect(3'(c), 1'(b), 1'b1);
            expect_out(3'(c), 1'(b));
            check(irq, 0);
            drop;
         end
      end
      detect(CDSC_CLS_NONE, 1'b1, 1'b0);
      expect_out(CDSC_CLS_NONSTD, 1'b1);
      rd_chk(ADDR_CTRL, 32'h53);
      drop;
      rd_chk(ADDR_IRQ_STAT, 32'h5);
      axi_wr(ADDR_IRQ_MASK, 32'h2, RESP_OKAY);
      detect(CDSC_CLS_DCP, 1'b0, 1'b1);
      expect_out(CDSC_CLS_DCP, 1'b0);
      // a short good-battery pulse must start the count over
      tick(DBT - 40);
      bat_cmd <= 1'b1;
      tick(3);
      bat_cmd <= 1'b0;
      tick(DBT - 20);
      check(ca_oe, 1);
      for (i = 0; i < 60; i++) begin
         @(posedge ref_clk);
         if (ca_oe === 1'b0) break;
      end
      bound(i, 60);
      tick(2);
      check({found, chg_pin, sw_pin, irq}, 4'h7);
      rd_chk(ADDR_IRQ_STAT, 32'h3);
      detect(CDSC_CLS_DCP, 1'b1, 1'b1);
      expect_out(CDSC_CLS_DCP, 1'b1);
      summarize;
   end
endmodule : cdsc_top_tb
